// ### verilog/rct_timer_map.svh
// Register offsets, field positions and reset values of the timer pair
`ifndef RCT_TIMER_MAP_SVH
`define RCT_TIMER_MAP_SVH

`define RCT_ADDR_T2_RELOAD_LO 8'h1b
`define RCT_ADDR_T2_COUNT_HI 8'h1c
`define RCT_ADDR_T2_COUNT_LO 8'h1d
`define RCT_ADDR_T3_CONTROL 8'h1e
`define RCT_ADDR_T3_RELOAD_HI 8'h1f
`define RCT_ADDR_T3_RELOAD_LO 8'h20
`define RCT_ADDR_T3_COUNT_HI 8'h21
`define RCT_ADDR_T3_COUNT_LO 8'h22
`define RCT_ADDR_T3_COMMAND 8'h2f

`define RCT_CTL_WMASK 8'hbb
`define RCT_CTL_RSVD_HI_BIT 6
`define RCT_CTL_RSVD_LO_BIT 2
`define RCT_CMD_START_BIT 0
`define RCT_CMD_STOP_BIT 1
`define RCT_CMD_CLEAR_BIT 2
`define RCT_STAT_RUN_BIT 0
`define RCT_STAT_FLAG_BIT 1

`define RCT_RESET_BYTE 8'h00
`define RCT_RESET_WORD 16'h0000
`define RCT_RESET_DIV 6'h00
`define RCT_DIV_LAST 6'h3f
`define RCT_DIV_STEP 6'h01
`define RCT_COUNT_STEP 16'h0001

`endif

// ### verilog/rct_pkg.sv
// Types shared by the timer pair
package rct_pkg;

    typedef enum logic [1:0] {
        RCT_START_SOFTWARE = 2'b00,
        RCT_START_TX_END = 2'b01,
        RCT_START_TRIM_HOLD = 2'b10,
        RCT_START_TRIM_WRAP = 2'b11
    } rct_start_type;

    typedef enum logic [1:0] {
        RCT_TICK_SYSTEM = 2'b00,
        RCT_TICK_DIV64 = 2'b01,
        RCT_TICK_TIMER0 = 2'b10,
        RCT_TICK_TIMER1 = 2'b11
    } rct_tick_type;

    typedef enum logic {
        RCT_IDLE = 1'b0,
        RCT_RUN = 1'b1
    } rct_state_type;

    typedef struct packed {
        logic stopOnReceive;
        logic reserved6;
        rct_start_type startModeField;
        logic autoReloadEnable;
        logic reserved2;
        rct_tick_type tickSourceSelect;
    } rct_control_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrEn;
        logic rdEn;
    } rct_bus_type;

endpackage : rct_pkg

// ### verilog/rct_timer_pair.sv
// Second timer reload/readback tail and complete third countdown timer
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "rct_timer_map.svh"

module rct_timer_pair
    import rct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire rct_bus_type bus,
    output logic [7:0] rdData,
    input wire logic [7:0] secondTimerReloadHigh,
    input wire logic secondTimerStart,
    input wire logic secondTimerTick,
    input wire logic rxFirstBits,
    input wire logic txEnd,
    input wire logic lowFrequencyOscillator,
    input wire logic timer0Underflow,
    input wire logic timer1Underflow,
    output logic timerUnderflowFlag,
    output logic thirdTimerRunning
);

    logic [7:0] secondTimerReloadLow;
    logic [15:0] secondTimerCount;
    rct_control_type thirdTimerControl;
    logic [7:0] thirdTimerReloadHigh;
    logic [7:0] thirdTimerReloadLow;
    logic [15:0] thirdTimerCount;
    rct_state_type state;
    logic [5:0] divCount;
    logic lfoSync1;
    logic lfoSync2;
    logic lfoPrev;
    logic lfoRise;
    logic divTick;
    logic tick;
    logic trimMode;
    logic running;
    logic swStart;
    logic swStop;
    logic swClear;
    logic startEvent;
    logic stopEvent;
    logic underflow;
    logic [15:0] thirdTimerReloadWord;
    logic [7:0] next_rdData;

    assign running = (state == RCT_RUN);
    assign thirdTimerRunning = running;
    assign thirdTimerReloadWord = {thirdTimerReloadHigh, thirdTimerReloadLow};
    assign trimMode = thirdTimerControl.startModeField[1];

    assign swStart = bus.wrEn && (bus.addr == `RCT_ADDR_T3_COMMAND)
        && bus.wrData[`RCT_CMD_START_BIT];
    assign swStop = bus.wrEn && (bus.addr == `RCT_ADDR_T3_COMMAND)
        && bus.wrData[`RCT_CMD_STOP_BIT];
    assign swClear = bus.wrEn && (bus.addr == `RCT_ADDR_T3_COMMAND)
        && bus.wrData[`RCT_CMD_CLEAR_BIT];

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            secondTimerReloadLow <= `RCT_RESET_BYTE;
            thirdTimerControl <= rct_control_type'(`RCT_RESET_BYTE);
            thirdTimerReloadHigh <= `RCT_RESET_BYTE;
            thirdTimerReloadLow <= `RCT_RESET_BYTE;
        end else if (bus.wrEn) begin
            case (bus.addr)
                `RCT_ADDR_T2_RELOAD_LO: begin
                    secondTimerReloadLow <= bus.wrData;
                end
                `RCT_ADDR_T3_CONTROL: begin
                    thirdTimerControl <=
                        rct_control_type'(bus.wrData & `RCT_CTL_WMASK);
                end
                `RCT_ADDR_T3_RELOAD_HI: begin
                    thirdTimerReloadHigh <= bus.wrData;
                end
                `RCT_ADDR_T3_RELOAD_LO: begin
                    thirdTimerReloadLow <= bus.wrData;
                end
                default: begin
                end
            endcase
        end
    end

    // second timer loads both reload bytes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            secondTimerCount <= `RCT_RESET_WORD;
        end else if (secondTimerStart) begin
            secondTimerCount <= {secondTimerReloadHigh, secondTimerReloadLow};
        end else if (secondTimerTick) begin
            secondTimerCount <= secondTimerCount - `RCT_COUNT_STEP;
        end
    end

    // Oscillator input synchroniser and edge detect
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            lfoSync1 <= 1'b0;
            lfoSync2 <= 1'b0;
            lfoPrev <= 1'b0;
        end else begin
            lfoSync1 <= lowFrequencyOscillator;
            lfoSync2 <= lfoSync1;
            lfoPrev <= lfoSync2;
        end
    end
    assign lfoRise = lfoSync2 && !lfoPrev;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            divCount <= `RCT_RESET_DIV;
        end else begin
            divCount <= divCount + `RCT_DIV_STEP;
        end
    end
    assign divTick = (divCount == `RCT_DIV_LAST);

    // Tick source selection
    always_comb begin
        case (thirdTimerControl.tickSourceSelect)
            RCT_TICK_SYSTEM: tick = 1'b1;
            RCT_TICK_DIV64: tick = divTick;
            RCT_TICK_TIMER0: tick = timer0Underflow;
            RCT_TICK_TIMER1: tick = timer1Underflow;
            default: tick = 1'b0;
        endcase
    end

    // Start and stop events
    always_comb begin
        startEvent = swStart;
        stopEvent = swStop;
        case (thirdTimerControl.startModeField)
            RCT_START_SOFTWARE: begin
            end
            RCT_START_TX_END: begin
                startEvent = swStart || txEnd;
            end
            RCT_START_TRIM_HOLD, RCT_START_TRIM_WRAP: begin
                startEvent = swStart || (lfoRise && !running);
                stopEvent = swStop || (lfoRise && running);
            end
            default: begin
            end
        endcase
        if (!trimMode && thirdTimerControl.stopOnReceive && rxFirstBits
            && running) begin
            stopEvent = 1'b1;
        end
    end

    // underflow except in trimming without underflow
    assign underflow = running && tick && (thirdTimerCount == `RCT_RESET_WORD)
        && (thirdTimerControl.startModeField != RCT_START_TRIM_HOLD)
        && !stopEvent && !startEvent;

    // Third timer counter and state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= RCT_IDLE;
            thirdTimerCount <= `RCT_RESET_WORD;
        end else if (stopEvent) begin
            state <= RCT_IDLE;
        end else if (startEvent) begin
            thirdTimerCount <= thirdTimerReloadWord;
            state <= RCT_RUN;
        end else if (running && tick) begin
            if (thirdTimerCount == `RCT_RESET_WORD) begin
                if (thirdTimerControl.startModeField
                    == RCT_START_TRIM_HOLD) begin
                    state <= RCT_IDLE;
                end else if (thirdTimerControl.autoReloadEnable) begin
                    thirdTimerCount <= thirdTimerReloadWord;
                end else begin
                    state <= RCT_IDLE;
                end
            end else begin
                thirdTimerCount <= thirdTimerCount - `RCT_COUNT_STEP;
            end
        end
    end

    // sticky flag, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            timerUnderflowFlag <= 1'b0;
        end else if (underflow) begin
            timerUnderflowFlag <= 1'b1;
        end else if (swClear) begin
            timerUnderflowFlag <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        next_rdData = `RCT_RESET_BYTE;
        if (bus.rdEn) begin
            case (bus.addr)
                `RCT_ADDR_T2_RELOAD_LO: next_rdData = secondTimerReloadLow;
                `RCT_ADDR_T2_COUNT_HI: next_rdData = secondTimerCount[15:8];
                `RCT_ADDR_T2_COUNT_LO: next_rdData = secondTimerCount[7:0];
                `RCT_ADDR_T3_CONTROL: next_rdData = thirdTimerControl;
                `RCT_ADDR_T3_RELOAD_HI: next_rdData = thirdTimerReloadHigh;
                `RCT_ADDR_T3_RELOAD_LO: next_rdData = thirdTimerReloadLow;
                `RCT_ADDR_T3_COUNT_HI: next_rdData = thirdTimerCount[15:8];
                `RCT_ADDR_T3_COUNT_LO: next_rdData = thirdTimerCount[7:0];
                `RCT_ADDR_T3_COMMAND: begin
                    next_rdData[`RCT_STAT_RUN_BIT] = running;
                    next_rdData[`RCT_STAT_FLAG_BIT] = timerUnderflowFlag;
                end
                default: next_rdData = `RCT_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdData <= `RCT_RESET_BYTE;
        end else begin
            rdData <= next_rdData;
        end
    end

    a_second_load:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        secondTimerStart |=> secondTimerCount
            == {$past(secondTimerReloadHigh), $past(secondTimerReloadLow)})
    else $error("second timer did not load reload bytes");

    a_receive_stop:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (running && rxFirstBits && thirdTimerControl.stopOnReceive
            && !trimMode && !startEvent) |=> !running)
    else $error("timer kept running after first bits");

    a_trim_ignores_rx:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (running && trimMode && rxFirstBits && !lfoRise && !swStop
            && !(tick && thirdTimerCount == `RCT_RESET_WORD)) |=> running)
    else $error("trimming timer stopped on receive");

    // no self start in software mode
    a_software_only:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (!running && !swStart && thirdTimerControl.startModeField
            == RCT_START_SOFTWARE) |=> !running)
    else $error("timer started without software");

    a_tx_end_start:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (txEnd && !stopEvent && thirdTimerControl.startModeField
            == RCT_START_TX_END) |=> running
            && thirdTimerCount == $past(thirdTimerReloadWord))
    else $error("transmit end did not start timer");

    a_auto_reload:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (underflow && thirdTimerControl.autoReloadEnable)
            |=> running && thirdTimerCount == $past(thirdTimerReloadWord)
            && timerUnderflowFlag)
    else $error("auto reload failed on underflow");

    a_stop_at_zero:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (underflow && !thirdTimerControl.autoReloadEnable) |=> !running
            && timerUnderflowFlag ##1 (!running || $past(startEvent)))
    else $error("timer did not stop at zero");

    a_count_step:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (running && !tick && !startEvent) |=> $stable(thirdTimerCount))
    else $error("count moved without tick");

    a_reserved_zero:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus.rdEn && bus.addr == `RCT_ADDR_T3_CONTROL)
            |=> rdData[`RCT_CTL_RSVD_HI_BIT] == 1'b0
            && rdData[`RCT_CTL_RSVD_LO_BIT] == 1'b0)
    else $error("reserved control bits not zero");

    a_count_decrement:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (running && tick && thirdTimerCount != `RCT_RESET_WORD
            && !startEvent && !stopEvent)
            |=> thirdTimerCount == $past(thirdTimerCount) - `RCT_COUNT_STEP)
    else $error("count did not step down by one");

    a_cascade_step:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (running && thirdTimerControl.tickSourceSelect == RCT_TICK_TIMER0
            && thirdTimerCount != `RCT_RESET_WORD
            && !startEvent && !stopEvent)
            |=> thirdTimerCount
            == $past(thirdTimerCount) - {15'h0000, $past(timer0Underflow)})
    else $error("cascade count out of step");

    a_start_load:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (startEvent && !stopEvent) |=> running
            && thirdTimerCount == $past(thirdTimerReloadWord))
    else $error("start did not load reload word");

    a_div_period:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        divTick |-> ##64 divTick)
    else $error("divided tick period wrong");

    a_second_count:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (secondTimerTick && !secondTimerStart) |=> secondTimerCount
            == $past(secondTimerCount) - `RCT_COUNT_STEP)
    else $error("second timer count did not step");

    a_hold_no_flag:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (running && tick && thirdTimerCount == `RCT_RESET_WORD
            && thirdTimerControl.startModeField == RCT_START_TRIM_HOLD
            && !startEvent && !stopEvent)
            |=> !running && !$rose(timerUnderflowFlag))
    else $error("hold mode underflowed");

    a_flag_sticky:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (timerUnderflowFlag && !swClear) |=> timerUnderflowFlag)
    else $error("underflow flag lost without clear");

endmodule : rct_timer_pair

// ### bench/rct_timer_pair_tb.sv
// Self-checking bench of the timer pair
`timescale 1ns/10ps
module rct_timer_pair_tb
    import rct_pkg::*;
;
    logic clk_sys;
    logic resetn;
    rct_bus_type bus;
    logic [7:0] rdData;
    logic [7:0] secondTimerReloadHigh;
    logic secondTimerStart;
    logic secondTimerTick;
    logic rxFirstBits;
    logic txEnd;
    logic lowFrequencyOscillator;
    logic timer0Underflow;
    logic timer1Underflow;
    logic timerUnderflowFlag;
    logic thirdTimerRunning;
    int failCount;
    int nChecks;
    int cycles;
    int n;
    int rl;
    int ex;
    int w;
    logic [7:0] rv;
    logic [7:0] hv;
    int srcQ[$];

    rct_timer_pair rct_timer_pair_inst (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .bus(bus),
        .rdData(rdData),
        .secondTimerReloadHigh(secondTimerReloadHigh),
        .secondTimerStart(secondTimerStart),
        .secondTimerTick(secondTimerTick),
        .rxFirstBits(rxFirstBits),
        .txEnd(txEnd),
        .lowFrequencyOscillator(lowFrequencyOscillator),
        .timer0Underflow(timer0Underflow),
        .timer1Underflow(timer1Underflow),
        .timerUnderflowFlag(timerUnderflowFlag),
        .thirdTimerRunning(thirdTimerRunning)
    );

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] expv);
        nChecks++;
        if (seen !== expv) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", nm, expv, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
        #1;
    endtask : wr

    task automatic rdChk(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
        @(posedge clk_sys);
        bus <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        chk(nm, {8'h00, rdData}, {8'h00, e});
    endtask : rdChk

    task automatic pulse(input int which);
        @(posedge clk_sys);
        case (which)
            0: txEnd <= 1'b1;
            1: rxFirstBits <= 1'b1;
            2: timer0Underflow <= 1'b1;
            3: timer1Underflow <= 1'b1;
            4: secondTimerStart <= 1'b1;
            default: secondTimerTick <= 1'b1;
        endcase
        @(posedge clk_sys);
        {txEnd, rxFirstBits, timer0Underflow, timer1Underflow} <= '0;
        {secondTimerStart, secondTimerTick} <= '0;
        #1;
    endtask : pulse

    task automatic start3(input int r, input logic [7:0] ctl);
        wr(8'h1f, 8'(r >> 8));
        wr(8'h20, 8'(r));
        wr(8'h1e, ctl);
        wr(8'h2f, 8'h01);
    endtask : start3

    task automatic runLen(output int cnt);
        cnt = 0;
        while (thirdTimerRunning === 1'b1 && cnt < 2000) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask : runLen

    task automatic lfoRise(input int hold);
        @(posedge clk_sys);
        lowFrequencyOscillator <= 1'b0;
        repeat (6) @(posedge clk_sys);
        lowFrequencyOscillator <= 1'b1;
        repeat (hold) @(posedge clk_sys);
        #1;
    endtask : lfoRise

    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cut a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            summarize();
        end
    end

    initial begin
        {resetn, bus, secondTimerReloadHigh, secondTimerStart} = '0;
        {secondTimerTick, rxFirstBits, txEnd, lowFrequencyOscillator} = '0;
        {timer0Underflow, timer1Underflow} = '0;
        {failCount, nChecks} = '0;
        void'($urandom(90435));
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        for (w = 8'h1b; w <= 8'h30; w++) begin
            rdChk("reset value", 8'(w), 8'h00);
        end
        $display("done: reset values");
        rv = 8'($urandom);
        wr(8'h1b, rv);
        rdChk("t2 reload low", 8'h1b, rv);
        wr(8'h1f, rv ^ 8'h5a);
        rdChk("t3 reload high", 8'h1f, rv ^ 8'h5a);
        wr(8'h20, ~rv);
        rdChk("t3 reload low", 8'h20, ~rv);
        wr(8'h1e, 8'hff);
        rdChk("control", 8'h1e, 8'hbb);
        wr(8'h21, 8'hff);
        rdChk("t3 count high", 8'h21, 8'h00);
        wr(8'h30, 8'hff);
        rdChk("unmapped", 8'h30, 8'h00);
        $display("done: register access");
        rl = 2 + $urandom % 8;
        start3(rl, 8'h00);
        runLen(n);
        chk("run length", 16'(n), 16'(rl + 1));
        chk("flag", {15'h0, timerUnderflowFlag}, 16'h1);
        rdChk("count low", 8'h22, 8'h00);
        wr(8'h2f, 8'h04);
        chk("flag cleared", {15'h0, timerUnderflowFlag}, 16'h0);
        pulse(0);
        chk("mode0 txend", {15'h0, thirdTimerRunning}, 16'h0);
        $display("done: single run");
        start3(rl, 8'h08);
        repeat (3 * (rl + 1)) @(posedge clk_sys);
        #1;
        chk("auto running", {15'h0, thirdTimerRunning}, 16'h1);
        chk("auto flag", {15'h0, timerUnderflowFlag}, 16'h1);
        wr(8'h2f, 8'h06);
        chk("stopped", {15'h0, thirdTimerRunning}, 16'h0);
        $display("done: auto reload");
        rl = 1000 + $urandom % 1000;
        start3(rl, 8'h02);
        ex = rl;
        for (w = 0; w < 24; w++) begin
            if (w == 12) begin
                wr(8'h1e, 8'h03);
            end
            n = 2 + $urandom % 2;
            pulse(n);
            srcQ.push_back(n);
        end
        foreach (srcQ[i]) begin
            if (srcQ[i] == (i < 12 ? 2 : 3)) begin
                ex--;
            end
        end
        wr(8'h20, 8'h00);
        wr(8'h1f, 8'h00);
        rdChk("cascade high", 8'h21, 8'(ex >> 8));
        rdChk("cascade low", 8'h22, 8'(ex));
        wr(8'h2f, 8'h02);
        $display("done: cascade");
        rl = 2;
        start3(rl, 8'h01);
        runLen(n);
        chk("div64 length", 16'(n >= 64 * rl && n <= 64 * rl + 65), 1);
        wr(8'h2f, 8'h04);
        $display("done: divided tick");
        start3(5, 8'h12);
        wr(8'h2f, 8'h02);
        pulse(0);
        chk("txend start", {15'h0, thirdTimerRunning}, 16'h1);
        // count holds at reload with no timer0 underflow pending
        rdChk("txend count", 8'h22, 8'h05);
        pulse(1);
        chk("no stop rx", {15'h0, thirdTimerRunning}, 16'h1);
        wr(8'h2f, 8'h02);
        wr(8'h1e, 8'h92);
        pulse(0);
        pulse(1);
        chk("stop rx", {15'h0, thirdTimerRunning}, 16'h0);
        $display("done: event start");
        wr(8'h1e, 8'ha2);
        lfoRise(6);
        chk("trim start", {15'h0, thirdTimerRunning}, 16'h1);
        pulse(1);
        chk("rx ignored", {15'h0, thirdTimerRunning}, 16'h1);
        lfoRise(6);
        chk("trim stop", {15'h0, thirdTimerRunning}, 16'h0);
        wr(8'h1e, 8'h20);
        lfoRise(20);
        chk("hold end", {15'h0, thirdTimerRunning}, 16'h0);
        chk("hold no flag", {15'h0, timerUnderflowFlag}, 16'h0);
        wr(8'h1e, 8'h30);
        lfoRise(20);
        chk("wrap flag", {15'h0, timerUnderflowFlag}, 16'h1);
        $display("done: trimming");
        rv = 8'($urandom);
        hv = 8'($urandom);
        wr(8'h1b, rv);
        @(posedge clk_sys);
        secondTimerReloadHigh <= hv;
        pulse(4);
        rdChk("t2 high", 8'h1c, hv);
        rdChk("t2 low", 8'h1d, rv);
        n = 1 + $urandom % 5;
        repeat (n) pulse(5);
        ex = {hv, rv} - n;
        rdChk("t2 tick high", 8'h1c, 8'(ex >> 8));
        rdChk("t2 tick low", 8'h1d, 8'(ex));
        $display("done: second timer");
        summarize();
    end
endmodule : rct_timer_pair_tb
